// [rtl/sldg_pkg.sv]
// Shared constants and types of the serial link diagnostics and GPIO block
package sldg_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_LOCAL_DATA = 8'h0D;
	localparam logic [7:0] ADDR_PIN_CTL    = 8'h0E;
	localparam logic [7:0] ADDR_SENS_CTL   = 8'h17;
	localparam logic [7:0] ADDR_SENS_GAIN  = 8'h18;
	localparam logic [7:0] ADDR_SENS_LIM   = 8'h1A;
	localparam logic [7:0] ADDR_ALM_FWD    = 8'h1E;
	localparam logic [7:0] ADDR_CLR_CTL    = 8'h49;
	localparam logic [7:0] ADDR_LINK_STS   = 8'h52;
	localparam logic [7:0] ADDR_PIN_STS    = 8'h53;
	localparam logic [7:0] ADDR_BIST_CNT   = 8'h54;
	localparam logic [7:0] ADDR_CRC_LO     = 8'h55;
	localparam logic [7:0] ADDR_CRC_HI     = 8'h56;
	localparam logic [7:0] ADDR_SENS_STS   = 8'h57;

	// Reset values
	localparam logic [7:0] REG_RST     = 8'h00;
	localparam logic [7:0] PIN_CTL_RST = 8'h0F;

	// Link status bits
	localparam int LS_CRC_ERR = 1;
	localparam int LS_PLL     = 2;
	localparam int LS_BIST    = 3;
	localparam int LS_RLOCK   = 6;

	// Clear-control bits, self-clearing
	localparam int CLR_CRC_BIT  = 3;
	localparam int CLR_BIST_BIT = 5;

	// Pin control and local data layout
	localparam int PIN_IE_LSB  = 0;
	localparam int PIN_OE_LSB  = 4;
	localparam int LD_VAL_LSB  = 0;
	localparam int LD_RSEL_LSB = 4;

	// Sensor control, limits, status and forwarding bits
	localparam int SC_VOLT_EN  = 1;
	localparam int SC_TEMP_EN  = 2;
	localparam int SC_PIN_SEL  = 3;
	localparam int LIM_LO_LSB  = 0;
	localparam int LIM_UP_LSB  = 4;
	localparam int SS_TEMP_LO  = 0;
	localparam int SS_TEMP_HI  = 1;
	localparam int SS_VOLT_LO  = 2;
	localparam int SS_VOLT_HI  = 3;
	localparam int SS_CODE_LSB = 4;
	localparam int SS_ALARM    = 7;
	localparam int AF_VOLT     = 0;
	localparam int AF_TEMP     = 1;
	localparam int CODE_W      = 3;

	// Back-channel frame: payload above a trailing CRC field
	localparam int             BC_FRAME_BITS = 30;
	localparam int             BC_CRC_W      = 6;
	localparam logic [5:0]     BC_CRC_POLY   = 6'h03;
	localparam logic [5:0]     BC_CRC_INIT   = 6'h3F;
	localparam int             BF_BIST       = 6;
	localparam int             BF_RLOCK      = 7;
	localparam int             BF_GPIO_LSB   = 8;

	// Forward test pattern generator
	localparam int              PRBS_W     = 15;
	localparam int              PRBS_TAP_A = 14;
	localparam int              PRBS_TAP_B = 13;
	localparam logic [14:0]     PRBS_SEED  = 15'h7FFF;

	// Back-channel receiver states, Gray along the frame path
	typedef enum logic [1:0] {
		BC_IDLE  = 2'h0,
		BC_SHIFT = 2'h1,
		BC_CHECK = 2'h3
	} sldg_bc_state_t;

endpackage

// [rtl/sldg_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sldg_sync3 #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Asynchronous inputs
	input  wire logic [W-1:0] async_in,
	// Filtered level
	output logic      [W-1:0] level
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} sldg_sync_t;

	sldg_sync_t st_r;
	sldg_sync_t st_nxt;

	// Level follows only once stages two and three agree
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.s1  = async_in;
		st_nxt.s2  = st_r.s1;
		st_nxt.s3  = st_r.s2;
		st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 | st_r.s3));
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign level = st_r.lvl;

endmodule

// [rtl/sldg_satcnt.sv]
// Saturating event counter with synchronous clear
`timescale 1ns/1ps
module sldg_satcnt #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Events
	input  wire logic         inc,
	input  wire logic         clr,
	// Count
	output logic      [W-1:0] count
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} sldg_cnt_t;

	sldg_cnt_t st_r;
	sldg_cnt_t st_nxt;

	// Clear restarts from zero; an event in that cycle still counts
	always_comb
	begin
		st_nxt = st_r;
		if (clr)
			st_nxt.cnt = {{(W-1){1'b0}}, inc};
		else if (inc && st_r.cnt != {W{1'b1}})
			st_nxt.cnt = st_r.cnt + {{(W-1){1'b0}}, 1'b1}; // R25
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign count = st_r.cnt;

	a_count_saturate: assert property (@(posedge clk) disable iff (!rst_b) // R25
		(st_r.cnt == {W{1'b1}} && !clr) |=> st_r.cnt == {W{1'b1}})
		else $error("counter left saturation without clear");

endmodule

// [rtl/sldg_top.sv]
// Link diagnostics, self-test, sensor limits and GPIO register bank
// Operation
// R1: Link status bit 2 shows forward PLL lock.
// R2: Link status bit 6 shows remote receiver lock from back channel.
// R3: Link status bit 1 sets on back-channel CRC error.
// R4: Back-channel CRC errors counted in two byte registers 0x55, 0x56.
// R5: Writing one to clear bit 3 zeroes the CRC error counter.
// R6: During self-test, status bit 3 sets on self-test CRC error.
// R7: Self-test error total readable in byte register 0x54.
// R8: Writing one to clear bit 5 zeroes the self-test error counter.
// R9: Each voltage and temperature measurement is a 3-bit code.
// R10: Alarm raised when a code lies outside programmed limits.
// R11: Either of the first two pins may be the sensed voltage.
// R12: Sensor enable and sensed pin set in sensor control register.
// R13: Sensor status bits 2 and 3 show voltage below or above limits.
// R14: Enabled sensor alarms are forwarded over the control link.
// R15: Self-test enable from back channel starts pseudo-random forward stream.
// R16: During self-test every back-channel frame CRC is checked and counted.
// R17: The remote receiver starts self-test only in synchronous clocking mode.
// R18: Any pin may output a frame alignment slot from back channel.
// R19: Four pins, read and controlled through three registers.
// R20: Pin status register returns each pin level, input or output.
// R21: After reset all pins are inputs; input enables in bits 3:0.
// R22: Output enables in pin control bits 7:4, one per pin.
// R23: Software never sets input and output enable of one pin together.
// R24: Output pins may carry remote data, selected in local data register.
// R25: Error counters saturate; counter clear bits clear themselves.
`timescale 1ns/1ps
module sldg_top #(
	parameter int NPINS = 4
) (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	// Register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [7:0]                     reg_rdata,
	// Forward link
	input  wire logic                           fwd_pll_lock_in,
	input  wire logic                           fwd_data_in,
	output logic                                fwd_tx_bit,
	output logic                                fwd_tx_test,
	output logic      [NPINS-1:0]               fwd_gpio,
	output logic      [1:0]                     sensor_alarm_fwd,
	// Back channel
	input  wire logic                           bc_clk,
	input  wire logic                           bc_data,
	input  wire logic                           bc_frame,
	// Sensor converters
	input  wire logic                           adc_valid,
	input  wire logic [sldg_pkg::CODE_W-1:0]    adc_volt0_code,
	input  wire logic [sldg_pkg::CODE_W-1:0]    adc_volt1_code,
	input  wire logic [sldg_pkg::CODE_W-1:0]    adc_temp_code,
	// General pins
	input  wire logic [NPINS-1:0]               gpio_in,
	output logic      [NPINS-1:0]               gpio_out,
	output logic      [NPINS-1:0]               gpio_oe
);

	localparam int NB_W = $clog2(sldg_pkg::BC_FRAME_BITS + 1);
	localparam int PL_W = sldg_pkg::BC_FRAME_BITS - sldg_pkg::BC_CRC_W;
	localparam int SY_W = NPINS + 4;

	typedef struct packed {
		sldg_pkg::sldg_bc_state_t      bst;
		logic [sldg_pkg::BC_FRAME_BITS-1:0] sh;
		logic [NB_W-1:0]               nbits;
		logic                          bclk_d;
		logic                          bist_on;
		logic                          rlock;
		logic [NPINS-1:0]              bc_gpio;
		logic                          fwd_pll_locked;
		logic                          crc_flag;
		logic                          selftest_error_flag;
		logic [7:0]                    local_data;
		logic [7:0]                    pin_ctl;
		logic [7:0]                    sens_ctl;
		logic [7:0]                    sens_gain;
		logic [7:0]                    sens_lim;
		logic [7:0]                    alm_fwd;
		logic [7:0]                    clr_ctl;
		logic [sldg_pkg::CODE_W-1:0]   vcode;
		logic [sldg_pkg::CODE_W-1:0]   tcode;
		logic [3:0]                    alarm;
		logic [1:0]                    alm_out;
		logic [sldg_pkg::PRBS_W-1:0]   prbs;
		logic                          tx_bit;
		logic                          tx_test;
		logic [NPINS-1:0]              gpo;
		logic [NPINS-1:0]              gpoe;
		logic [NPINS-1:0]              fgp;
		logic [7:0]                    rdata;
	} sldg_state_t;

	sldg_state_t                     st_r;
	sldg_state_t                     st_nxt;
	logic        [SY_W-1:0]          sy_lvl;
	logic        [NPINS-1:0]         pin_level_readback;
	logic                            lock_lvl;
	logic                            bclk_lvl;
	logic                            bdat_lvl;
	logic                            bfrm_lvl;
	logic                            frame_ok;
	logic                            crc_bad;
	logic                            bist_bad;
	logic                            wr_clr;
	logic                            backlink_error_count_clear;
	logic                            selftest_count_clear;
	logic        [15:0]              crc_cnt;
	logic        [7:0]               selftest_error_total;
	logic        [sldg_pkg::CODE_W-1:0] lim_lo;
	logic        [sldg_pkg::CODE_W-1:0] lim_up;

	// CRC over the frame payload, most significant bit first
	function automatic logic [5:0] crc6(input logic [PL_W-1:0] d);
		logic [5:0] c;
		c = sldg_pkg::BC_CRC_INIT;
		for (int i = PL_W - 1; i >= 0; i--)
		begin
			if (c[5] ^ d[i])
				c = {c[4:0], 1'b0} ^ sldg_pkg::BC_CRC_POLY;
			else
				c = {c[4:0], 1'b0};
		end
		return c;
	endfunction

	// Pin-side inputs enter through three stages
	sldg_sync3 #(
		.W (SY_W)
	) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in ({gpio_in, bc_frame, bc_data, bc_clk, fwd_pll_lock_in}),
		.level    (sy_lvl)
	);

	assign lock_lvl           = sy_lvl[0];
	assign bclk_lvl           = sy_lvl[1];
	assign bdat_lvl           = sy_lvl[2];
	assign bfrm_lvl           = sy_lvl[3];
	assign pin_level_readback = sy_lvl[SY_W-1:4];

	// Frame check at the end of each back-channel frame
	assign frame_ok = st_r.bst == sldg_pkg::BC_CHECK
		&& st_r.nbits == NB_W'(sldg_pkg::BC_FRAME_BITS);
	assign crc_bad  = frame_ok
		&& crc6(st_r.sh[sldg_pkg::BC_FRAME_BITS-1:sldg_pkg::BC_CRC_W])
		!= st_r.sh[sldg_pkg::BC_CRC_W-1:0]; // R3
	assign bist_bad = crc_bad && st_r.bist_on; // R16

	// Self-clearing counter clears from the clear-control register
	assign wr_clr                     = reg_wr && reg_addr == sldg_pkg::ADDR_CLR_CTL;
	assign backlink_error_count_clear = wr_clr && reg_wdata[sldg_pkg::CLR_CRC_BIT]; // R5
	assign selftest_count_clear       = wr_clr && reg_wdata[sldg_pkg::CLR_BIST_BIT]; // R8

	// Back-channel CRC error counter, two byte registers
	sldg_satcnt #(
		.W (16)
	) u_crc_cnt (
		.clk   (clk),
		.rst_b (rst_b),
		.inc   (crc_bad),
		.clr   (backlink_error_count_clear),
		.count (crc_cnt)
	);

	// Self-test error counter
	sldg_satcnt #(
		.W (8)
	) u_bist_cnt (
		.clk   (clk),
		.rst_b (rst_b),
		.inc   (bist_bad),
		.clr   (selftest_count_clear),
		.count (selftest_error_total)
	);

	assign lim_lo = st_r.sens_lim[sldg_pkg::LIM_LO_LSB +: sldg_pkg::CODE_W];
	assign lim_up = st_r.sens_lim[sldg_pkg::LIM_UP_LSB +: sldg_pkg::CODE_W];

	// Next-state logic for the whole block
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.bclk_d = bclk_lvl;

		// Back-channel frame receiver
		unique case (st_r.bst)
			sldg_pkg::BC_IDLE:
				if (bfrm_lvl)
				begin
					st_nxt.bst   = sldg_pkg::BC_SHIFT;
					st_nxt.nbits = '0;
				end
			sldg_pkg::BC_SHIFT:
			begin
				if (bclk_lvl && !st_r.bclk_d)
				begin
					st_nxt.sh = {st_r.sh[sldg_pkg::BC_FRAME_BITS-2:0], bdat_lvl};
					if (st_r.nbits != {NB_W{1'b1}})
						st_nxt.nbits = st_r.nbits + NB_W'(1);
				end
				if (!bfrm_lvl)
					st_nxt.bst = sldg_pkg::BC_CHECK;
			end
			sldg_pkg::BC_CHECK:
			begin
				st_nxt.bst = sldg_pkg::BC_IDLE;
				if (frame_ok && !crc_bad)
				begin
					st_nxt.bist_on = st_r.sh[sldg_pkg::BF_BIST]; // R15
					st_nxt.rlock   = st_r.sh[sldg_pkg::BF_RLOCK]; // R2
					st_nxt.bc_gpio = st_r.sh[sldg_pkg::BF_GPIO_LSB +: NPINS]; // R18
				end
			end
			default:
				st_nxt.bst = sldg_pkg::BC_IDLE;
		endcase

		// Status flags; a new error wins over a read clear
		st_nxt.fwd_pll_locked = lock_lvl; // R1
		if (reg_rd && reg_addr == sldg_pkg::ADDR_LINK_STS)
		begin
			st_nxt.crc_flag            = 1'b0;
			st_nxt.selftest_error_flag = 1'b0;
		end
		if (crc_bad)
			st_nxt.crc_flag = 1'b1; // R3
		if (bist_bad)
			st_nxt.selftest_error_flag = 1'b1; // R6

		// Register writes
		if (reg_wr)
		begin
			unique case (reg_addr)
				sldg_pkg::ADDR_LOCAL_DATA: st_nxt.local_data = reg_wdata; // R24
				sldg_pkg::ADDR_PIN_CTL:    st_nxt.pin_ctl    = reg_wdata; // R19
				sldg_pkg::ADDR_SENS_CTL:   st_nxt.sens_ctl   = reg_wdata; // R12
				sldg_pkg::ADDR_SENS_GAIN:  st_nxt.sens_gain  = reg_wdata;
				sldg_pkg::ADDR_SENS_LIM:   st_nxt.sens_lim   = reg_wdata;
				sldg_pkg::ADDR_ALM_FWD:    st_nxt.alm_fwd    = reg_wdata; // R14
				sldg_pkg::ADDR_CLR_CTL:
				begin
					st_nxt.clr_ctl                        = reg_wdata;
					st_nxt.clr_ctl[sldg_pkg::CLR_CRC_BIT]  = 1'b0; // R25
					st_nxt.clr_ctl[sldg_pkg::CLR_BIST_BIT] = 1'b0; // R25
				end
				default: ;
			endcase
		end

		// Sensor sampling and limit compare
		if (adc_valid)
		begin
			st_nxt.vcode = st_r.sens_ctl[sldg_pkg::SC_PIN_SEL] ? adc_volt1_code
				: adc_volt0_code; // R11 R9
			st_nxt.tcode = adc_temp_code; // R9
		end
		st_nxt.alarm = '0;
		if (st_r.sens_ctl[sldg_pkg::SC_VOLT_EN])
		begin
			st_nxt.alarm[sldg_pkg::SS_VOLT_LO] = st_r.vcode < lim_lo; // R10 R13
			st_nxt.alarm[sldg_pkg::SS_VOLT_HI] = st_r.vcode > lim_up; // R10 R13
		end
		if (st_r.sens_ctl[sldg_pkg::SC_TEMP_EN])
		begin
			st_nxt.alarm[sldg_pkg::SS_TEMP_LO] = st_r.tcode < lim_lo; // R10
			st_nxt.alarm[sldg_pkg::SS_TEMP_HI] = st_r.tcode > lim_up; // R10
		end
		st_nxt.alm_out[sldg_pkg::AF_VOLT] = st_r.alm_fwd[sldg_pkg::AF_VOLT]
			&& (st_r.alarm[sldg_pkg::SS_VOLT_LO] || st_r.alarm[sldg_pkg::SS_VOLT_HI]); // R14
		st_nxt.alm_out[sldg_pkg::AF_TEMP] = st_r.alm_fwd[sldg_pkg::AF_TEMP]
			&& (st_r.alarm[sldg_pkg::SS_TEMP_LO] || st_r.alarm[sldg_pkg::SS_TEMP_HI]); // R14

		// Forward stream: pattern during self-test, payload otherwise
		st_nxt.tx_test = st_r.bist_on; // R15
		if (st_r.bist_on)
		begin
			st_nxt.prbs   = {st_r.prbs[sldg_pkg::PRBS_W-2:0],
				st_r.prbs[sldg_pkg::PRBS_TAP_A] ^ st_r.prbs[sldg_pkg::PRBS_TAP_B]}; // R15
			st_nxt.tx_bit = st_r.prbs[sldg_pkg::PRBS_W-1];
		end
		else
		begin
			st_nxt.prbs   = sldg_pkg::PRBS_SEED;
			st_nxt.tx_bit = fwd_data_in;
		end

		// Pin drive: local value or back-channel slot per pin
		for (int i = 0; i < NPINS; i++)
		begin
			st_nxt.gpo[i]  = st_r.local_data[sldg_pkg::LD_RSEL_LSB + i] ? st_r.bc_gpio[i]
				: st_r.local_data[sldg_pkg::LD_VAL_LSB + i]; // R24 R18
			st_nxt.gpoe[i] = st_r.pin_ctl[sldg_pkg::PIN_OE_LSB + i]; // R22 R23
			st_nxt.fgp[i]  = st_r.pin_ctl[sldg_pkg::PIN_IE_LSB + i]
				&& pin_level_readback[i]; // R21
		end

		// Register reads
		st_nxt.rdata = sldg_pkg::REG_RST;
		if (reg_rd)
		begin
			unique case (reg_addr)
				sldg_pkg::ADDR_LOCAL_DATA: st_nxt.rdata = st_r.local_data;
				sldg_pkg::ADDR_PIN_CTL:    st_nxt.rdata = st_r.pin_ctl;
				sldg_pkg::ADDR_SENS_CTL:   st_nxt.rdata = st_r.sens_ctl;
				sldg_pkg::ADDR_SENS_GAIN:  st_nxt.rdata = st_r.sens_gain;
				sldg_pkg::ADDR_SENS_LIM:   st_nxt.rdata = st_r.sens_lim;
				sldg_pkg::ADDR_ALM_FWD:    st_nxt.rdata = st_r.alm_fwd;
				sldg_pkg::ADDR_CLR_CTL:    st_nxt.rdata = st_r.clr_ctl;
				sldg_pkg::ADDR_LINK_STS:
				begin
					st_nxt.rdata[sldg_pkg::LS_CRC_ERR] = st_r.crc_flag; // R3
					st_nxt.rdata[sldg_pkg::LS_PLL]     = st_r.fwd_pll_locked; // R1
					st_nxt.rdata[sldg_pkg::LS_BIST]    = st_r.selftest_error_flag; // R6
					st_nxt.rdata[sldg_pkg::LS_RLOCK]   = st_r.rlock; // R2
				end
				sldg_pkg::ADDR_PIN_STS:
					st_nxt.rdata[NPINS-1:0] = pin_level_readback; // R20
				sldg_pkg::ADDR_BIST_CNT:   st_nxt.rdata = selftest_error_total; // R7
				sldg_pkg::ADDR_CRC_LO:     st_nxt.rdata = crc_cnt[7:0]; // R4
				sldg_pkg::ADDR_CRC_HI:     st_nxt.rdata = crc_cnt[15:8]; // R4
				sldg_pkg::ADDR_SENS_STS:
				begin
					st_nxt.rdata[3:0] = st_r.alarm; // R13
					st_nxt.rdata[sldg_pkg::SS_CODE_LSB +: sldg_pkg::CODE_W] = st_r.vcode;
					st_nxt.rdata[sldg_pkg::SS_ALARM] = |st_r.alarm; // R10
				end
				default: ;
			endcase
		end
	end

	// State register; all pins start as inputs
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r         <= '0;
			st_r.pin_ctl <= sldg_pkg::PIN_CTL_RST; // R21
			st_r.prbs    <= sldg_pkg::PRBS_SEED;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs straight from state
	assign reg_rdata        = st_r.rdata;
	assign fwd_tx_bit       = st_r.tx_bit;
	assign fwd_tx_test      = st_r.tx_test;
	assign fwd_gpio         = st_r.fgp;
	assign sensor_alarm_fwd = st_r.alm_out;
	assign gpio_out         = st_r.gpo;
	assign gpio_oe          = st_r.gpoe;

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_bad_frame;
		st_r.bst == sldg_pkg::BC_CHECK && crc_bad;
	endsequence

	sequence s_link_read;
		reg_rd && reg_addr == sldg_pkg::ADDR_LINK_STS;
	endsequence

	a_pll_lock_read: assert property ( // R1
		s_link_read |=> reg_rdata[sldg_pkg::LS_PLL] == $past(st_r.fwd_pll_locked))
		else $error("lock bit read differs from lock state");
	a_crc_flag_set: assert property ( // R3
		s_bad_frame |=> st_r.crc_flag ##1 (st_r.crc_flag
		|| ($past(reg_rd) && $past(reg_addr) == sldg_pkg::ADDR_LINK_STS)))
		else $error("CRC error flag not set or lost");
	a_crc_count_up: assert property ( // R4
		s_bad_frame and !backlink_error_count_clear and crc_cnt != 16'hFFFF
		|=> crc_cnt == $past(crc_cnt) + 16'h0001)
		else $error("CRC counter did not advance");
	a_crc_clear: assert property ( // R5
		backlink_error_count_clear |=> crc_cnt <= 16'h0001
		##1 st_r.clr_ctl[sldg_pkg::CLR_CRC_BIT] == 1'b0)
		else $error("CRC counter not cleared");
	a_bist_flag_set: assert property ( // R6
		bist_bad |=> st_r.selftest_error_flag)
		else $error("self-test flag not set");
	a_bist_idle_count: assert property ( // R16
		!st_r.bist_on && !selftest_count_clear |=> $stable(selftest_error_total))
		else $error("self-test count moved outside self-test");
	a_bist_clear: assert property ( // R8
		selftest_count_clear |=> selftest_error_total <= 8'h01)
		else $error("self-test counter not cleared");
	a_volt_above: assert property ( // R13
		st_r.sens_ctl[sldg_pkg::SC_VOLT_EN] && st_r.vcode > lim_up && $stable(st_r.vcode)
		|=> st_r.alarm[sldg_pkg::SS_VOLT_HI])
		else $error("voltage above limit not flagged");
	a_prbs_running: assert property ( // R15
		st_r.bist_on [*2] |=> fwd_tx_test && st_r.prbs != $past(st_r.prbs))
		else $error("test pattern not advancing");
	a_pin_readback: assert property ( // R20
		reg_rd && reg_addr == sldg_pkg::ADDR_PIN_STS
		|=> reg_rdata[NPINS-1:0] == $past(pin_level_readback))
		else $error("pin status read differs from pin level");
	a_pins_reset_in: assert property (@(posedge clk) // R21
		$rose(rst_b) |-> st_r.pin_ctl == sldg_pkg::PIN_CTL_RST && gpio_oe == '0)
		else $error("pins not inputs after reset");

endmodule

// [verif/sldg_remote_model.sv]
// Remote receiver model driving back-channel frames
`timescale 1ns/1ps
module sldg_remote_model #(
	parameter bit SYNC_MODE = 1'b1
) (
	// Back channel
	output logic bc_clk,
	output logic bc_data,
	output logic bc_frame
);
	// Idle link, clock stands still
	initial
	begin
		bc_clk = 1'b0;
		bc_data = 1'b0;
		bc_frame = 1'b0;
	end

	// Frame of payload bits 29:6 and CRC, one CRC bit flipped when bad
	task automatic send(input logic [23:0] pay, input logic bad);
		logic [5:0]  crc;
		logic [29:0] frm;
		crc = sldg_pkg::BC_CRC_INIT;
		pay[0] = pay[0] & SYNC_MODE;
		for (int i = 23; i >= 0; i--)
		begin
			crc = {crc[4:0], 1'b0} ^ ((pay[i] ^ crc[5]) ? sldg_pkg::BC_CRC_POLY : 6'h00);
		end
		frm = {pay, crc ^ {5'h00, bad}};
		bc_frame = 1'b1;
		#125;
		for (int i = 29; i >= 0; i--)
		begin
			bc_data = frm[i];
			#62.5 bc_clk = 1'b1;
			#62.5 bc_clk = 1'b0;
		end
		#62.5 bc_frame = 1'b0;
		bc_data = ~bc_data; // Released line shows inverse
		#125;
	endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the link diagnostics and GPIO register bank
`timescale 1ns/1ps
module testbench;
	logic       clk;
	logic       rst_b;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       pll;
	logic       tx_test;
	logic [1:0] alm;
	logic       bclk;
	logic       bdat;
	logic       bfrm;
	logic       adc_v;
	logic [2:0] v0;
	logic [2:0] v1;
	logic [2:0] tc;
	logic [3:0] ext;
	logic [3:0] pin;
	logic [3:0] gout;
	logic [3:0] goe;
	logic       fdin;
	logic       txb;
	logic [3:0] fgp;
	int         error_cnt;
	int         n_compared;

	// Clock and pin wire
	always #2 clk = ~clk;
	assign pin = (goe & gout) | (~goe & ext);

	sldg_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .fwd_pll_lock_in(pll),
		.fwd_data_in(fdin), .fwd_tx_bit(txb), .fwd_tx_test(tx_test), .fwd_gpio(fgp),
		.sensor_alarm_fwd(alm), .bc_clk(bclk), .bc_data(bdat), .bc_frame(bfrm),
		.adc_valid(adc_v), .adc_volt0_code(v0), .adc_volt1_code(v1),
		.adc_temp_code(tc), .gpio_in(pin), .gpio_out(gout), .gpio_oe(goe));
	sldg_remote_model rx (.bc_clk(bclk), .bc_data(bdat), .bc_frame(bfrm));

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	// Reset values, unmapped and read-only places
	task automatic t_reset();
		rreg(8'h0E, 8'h0F);
		rreg(8'h30, 8'h00);
		wreg(8'h54, 8'hFF);
		rreg(8'h54, 8'h00);
		rreg(8'h52, 8'h04);
		// Lock dropped, forward bit follows payload input
		@(posedge clk);
		pll <= 1'b0;
		fdin <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk({7'h00, txb}, 8'h01);
		rreg(8'h52, 8'h00);
		@(posedge clk);
		pll <= 1'b1;
		fdin <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	// Bad frame flag, count, read clear, counter clear
	task automatic t_crc();
		rx.send(24'h000002, 1'b0);
		rreg(8'h52, 8'h44);
		rx.send(24'h000002, 1'b1);
		rreg(8'h52, 8'h46);
		rreg(8'h52, 8'h44);
		rreg(8'h55, 8'h01);
		rreg(8'h56, 8'h00);
		wreg(8'h49, 8'h08);
		rreg(8'h55, 8'h00);
		rreg(8'h49, 8'h00);
	endtask
	// Self-test pattern, error flag, count and clear
	task automatic t_bist();
		logic [31:0] pb;
		rx.send(24'h000003, 1'b0);
		chk({7'h00, tx_test}, 8'h01);
		// Line bits obey the pattern recurrence b[n+15] = b[n] ^ b[n+1]
		for (int n = 0; n < 32; n++)
		begin
			@(posedge clk);
			#1 pb[n] = txb;
		end
		for (int n = 0; n < 17; n++)
			chk({7'h00, pb[n+15]}, {7'h00, pb[n] ^ pb[n+1]});
		chk({7'h00, |pb}, 8'h01);
		rx.send(24'h000003, 1'b1);
		rreg(8'h52, 8'h4E);
		rreg(8'h54, 8'h01);
		wreg(8'h49, 8'h20);
		rreg(8'h54, 8'h00);
		rx.send(24'h000002, 1'b0);
		chk({7'h00, tx_test}, 8'h00);
	endtask
	// Output drive, live readback, frame slot on pin zero
	task automatic t_gpio();
		ext <= 4'hA;
		repeat (4) @(posedge clk);
		rreg(8'h53, 8'h0A);
		chk({4'h0, fgp}, 8'h0A);
		wreg(8'h0E, 8'hF0);
		wreg(8'h0D, 8'h05);
		repeat (6) @(posedge clk);
		chk({goe, gout}, 8'hF5);
		chk({4'h0, fgp}, 8'h00);
		rreg(8'h53, 8'h05);
		wreg(8'h0D, 8'h10);
		rx.send(24'h000006, 1'b0);
		chk({4'h0, gout}, 8'h01);
		wreg(8'h0E, 8'h0F);
		repeat (2) @(posedge clk);
		#1 chk({4'h0, goe}, 8'h00);
	endtask
	// Voltage on pin one above limit, then pin zero in range
	task automatic t_sens();
		wreg(8'h1A, 8'h62);
		rreg(8'h1A, 8'h62);
		wreg(8'h1E, 8'h01);
		for (int s = 1; s >= 0; s--)
		begin
			wreg(8'h17, {4'h0, s[0], 3'h6});
			@(posedge clk);
			adc_v <= 1'b1;
			@(posedge clk);
			adc_v <= 1'b0;
			repeat (4) @(posedge clk);
			rreg(8'h57, s ? 8'hF8 : 8'h30);
			chk({6'h00, alm}, s ? 8'h01 : 8'h00);
		end
		// Both codes below the lower limit, both alarms forwarded
		wreg(8'h1E, 8'h03);
		v0 <= 3'h1;
		tc <= 3'h1;
		@(posedge clk);
		adc_v <= 1'b1;
		@(posedge clk);
		adc_v <= 1'b0;
		repeat (4) @(posedge clk);
		rreg(8'h57, 8'h95);
		chk({6'h00, alm}, 8'h03);
	endtask

	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		pll = 1'b1;
		adc_v = 1'b0;
		v0 = 3'h3;
		v1 = 3'h7;
		tc = 3'h4;
		ext = 4'h0;
		fdin = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset();
		t_crc();
		t_bist();
		t_gpio();
		t_sens();
		give_verdict();
	end
endmodule
